// ===== actc_pkg.sv
package actc_pkg;
	// ----------------------------------------------------------------
	// register offsets within page 0
	// ----------------------------------------------------------------
	localparam logic [6:0] ACTC_OFS_PAGE = 7'h00;
	localparam logic [6:0] ACTC_OFS_RSVD_STAT = 7'h02;
	localparam logic [6:0] ACTC_OFS_THERMAL = 7'h03;
	localparam logic [6:0] ACTC_OFS_CLK_MUX = 7'h04;
	localparam logic [6:0] ACTC_OFS_PLL_PR = 7'h05;
	localparam logic [6:0] ACTC_OFS_PLL_J = 7'h06;
	localparam logic [6:0] ACTC_OFS_FRAC_UP = 7'h07;
	localparam logic [6:0] ACTC_OFS_FRAC_LO = 7'h08;
	localparam logic [6:0] ACTC_OFS_RSVD_A = 7'h09;
	localparam logic [6:0] ACTC_OFS_RSVD_B = 7'h0A;
	localparam logic [6:0] ACTC_OFS_FIRST_DIV = 7'h0B;
	localparam logic [6:0] ACTC_OFS_SECOND_DIV = 7'h0C;
	localparam logic [6:0] ACTC_OFS_OSR_UP = 7'h0D;
	localparam logic [6:0] ACTC_OFS_OSR_LO = 7'h0E;
	// ----------------------------------------------------------------
	// reset values and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] ACTC_RST_PAGE = 8'h00;
	localparam logic [1:0] ACTC_RST_SEL = 2'h0;
	localparam logic [2:0] ACTC_RST_PREDIV = 3'h1;
	localparam logic [3:0] ACTC_RST_RMULT = 4'h1;
	localparam logic [5:0] ACTC_RST_JMULT = 6'h04;
	localparam logic [13:0] ACTC_RST_FRAC = 14'h0000;
	localparam logic [6:0] ACTC_RST_DIV = 7'h01;
	localparam logic [9:0] ACTC_RST_OSR = 10'h080;
	localparam int ACTC_POWER_BIT = 7;
	localparam int ACTC_THERMAL_BIT = 1;
	// zero codes that stand for a field's largest value, and those largest values
	localparam logic [2:0] ACTC_PREDIV_MAX = 3'h0;
	localparam logic [3:0] ACTC_RMULT_MAX = 4'h0;
	localparam logic [8:0] ACTC_DIV_FULL = 9'h080;
	localparam logic [10:0] ACTC_OSR_FULL = 11'h400;
	localparam logic [4:0] ACTC_PREDIV_FULL = 5'h08;
	localparam logic [4:0] ACTC_RMULT_FULL = 5'h10;

	// clock source codes shared by both selectors
	typedef enum logic [1:0]
	{
		ACTC_SRC_MASTER = 2'b00,
		ACTC_SRC_BIT = 2'b01,
		ACTC_SRC_GENERAL = 2'b10,
		ACTC_SRC_LAST = 2'b11
	} actc_src_e;

	// register write strobe with its data
	typedef struct packed
	{
		logic valid;
		logic [6:0] addr;
		logic [7:0] data;
	} actc_wr_s;

	// decoded pll settings
	typedef struct packed
	{
		logic power;
		logic [4:0] prediv;
		logic [4:0] rmult;
		logic [5:0] jmult;
		logic [13:0] frac;
	} actc_pll_s;
endpackage : actc_pkg

// ===== actc_clk_mux.sv
`timescale 1ns/1ps
// four-way source selector, registered output
module actc_clk_mux
	import actc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [1:0] sel,
	input wire logic [3:0] src,
	output logic out_q
);
	// registered pick keeps the output straight from a flip-flop
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			out_q <= 1'b0;
		else
			out_q <= src[sel];
	end
endmodule : actc_clk_mux

// ===== actc_divider.sv
`timescale 1ns/1ps
// enable-gated counter divider, code zero means full range
module actc_divider
	import actc_pkg::*;
#(
	parameter int WIDTH = 7
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic power,
	input wire logic [WIDTH-1:0] code,
	input wire logic tick,
	output logic pulse_q
);
	// elaboration check: the count compare serves one to ten bits only
	if (WIDTH < 1 || WIDTH > 10)
	begin : g_width_check
		$error("actc_divider width out of range");
	end

	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] last;
	// code zero wraps to all ones, so the full 2**WIDTH range is kept
	assign last = code - WIDTH'(1);

	// count only while powered; restart from zero after power-down
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			count_q <= '0;
			pulse_q <= 1'b0;
		end
		else if (!power)
		begin
			count_q <= '0; // RL23
			pulse_q <= 1'b0; // RL23
		end
		else if (tick)
		begin
			pulse_q <= (count_q == last);
			count_q <= (count_q == last) ? '0 : count_q + 1'b1;
		end
		else
			pulse_q <= 1'b0;
	end
endmodule : actc_divider

// ===== actc_clock_cfg.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// clock tree configuration registers
// ----------------------------------------------------------------
// Operation
// RL1: pll reference picks master, bit, general, data
// RL2: codec clock picks master, bit, general, pll
// RL3: pll power bit, resets off
// RL4: pre-divider code zero means eight
// RL5: r multiplier code zero means sixteen
// RL6: j multiplier one to 63, reset four
// RL7: fraction split six upper, eight lower
// RL8: fraction upper waits for next lower write
// RL9: host writes lower right after upper
// RL10: first divider power bit, resets off
// RL11: first divider code zero means 128
// RL12: second divider power bit, resets off
// RL13: second divider code zero means 128
// RL14: oversample ratio two upper, eight lower
// RL15: oversample code zero means 1024
// RL16: host writes oversample lower after upper
// RL17: host picks ratio multiple of interpolation
// RL18: thermal bit low on trip, reset one
// RL19: host avoids reserved register and bits
// RL20: host writes zeros to reserved registers
// RL21: registers on page 0, reset page 0
// RL22: registers eight bits, d7 most significant
// RL23: unpowered divider idle, restarts clean
module actc_clock_cfg
	import actc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input actc_wr_s wr,
	input wire logic rd_valid,
	input wire logic [6:0] rd_addr,
	input wire logic master_pin,
	input wire logic bit_pin,
	input wire logic general_pin_one,
	input wire logic data_pin,
	input wire logic pll_clock,
	input wire logic overtemp_trip,
	output logic [7:0] rd_data_q,
	output logic rd_valid_q,
	output logic pll_reference_input,
	output logic codec_clock_input,
	output actc_pll_s pll_cfg_q,
	output logic first_div_pulse,
	output logic second_div_pulse,
	output logic [10:0] playback_oversample_ratio_q,
	output logic [7:0] page_q
);
	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [1:0] ref_sel_q, codec_sel_q, osr_up_q;
	logic pll_power_q, first_power_q, second_power_q;
	logic frac_armed_q, thermal_q, codec_prev_q, wr_p0;
	logic [2:0] prediv_q;
	logic [3:0] rmult_q;
	logic [5:0] jmult_q, frac_up_shadow_q;
	logic [13:0] frac_q;
	logic [6:0] first_code_q, second_code_q;
	logic [7:0] osr_lo_q, rsvd_a_q, rsvd_b_q, rd_mux;
	// only page 0 writes change these registers, other pages only drop the fraction arm; the page register is everywhere
	assign wr_p0 = wr.valid && (page_q == 8'h00); // RL21
	// page select, reachable from every page
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			page_q <= ACTC_RST_PAGE; // RL21
		else if (wr.valid && wr.addr == ACTC_OFS_PAGE)
			page_q <= wr.data;
	end

	// ----------------------------------------------------------------
	// clock selection and pll settings
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ref_sel_q <= ACTC_RST_SEL;
			codec_sel_q <= ACTC_RST_SEL;
		end
		else if (wr_p0 && wr.addr == ACTC_OFS_CLK_MUX)
		begin
			ref_sel_q <= wr.data[3:2]; // RL1
			codec_sel_q <= wr.data[1:0]; // RL2
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pll_power_q <= 1'b0; // RL3
			prediv_q <= ACTC_RST_PREDIV; // RL4
			rmult_q <= ACTC_RST_RMULT; // RL5
		end
		else if (wr_p0 && wr.addr == ACTC_OFS_PLL_PR)
		begin
			pll_power_q <= wr.data[ACTC_POWER_BIT]; // RL3
			prediv_q <= wr.data[6:4]; // RL4
			rmult_q <= wr.data[3:0]; // RL5
		end
	end

	// code zero is reserved; the register still stores what is written
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			jmult_q <= ACTC_RST_JMULT; // RL6
		else if (wr_p0 && wr.addr == ACTC_OFS_PLL_J)
			jmult_q <= wr.data[5:0]; // RL6
	end

	// ----------------------------------------------------------------
	// fraction pair: upper half held aside until lower follows
	// ----------------------------------------------------------------
	// any other register write in between drops the arm, so a stray
	// lower write never pairs with a stale upper half
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			frac_up_shadow_q <= 6'h00;
			frac_armed_q <= 1'b0;
			frac_q <= ACTC_RST_FRAC; // RL7
		end
		else if (wr_p0)
		begin
			frac_armed_q <= (wr.addr == ACTC_OFS_FRAC_UP); // RL8
			if (wr.addr == ACTC_OFS_FRAC_UP)
				frac_up_shadow_q <= wr.data[5:0]; // RL7
			if (wr.addr == ACTC_OFS_FRAC_LO)
			begin
				frac_q[7:0] <= wr.data; // RL7
				if (frac_armed_q)
					frac_q[13:8] <= frac_up_shadow_q; // RL8
			end
		end
		else if (wr.valid)
			frac_armed_q <= 1'b0; // RL8
	end

	// ----------------------------------------------------------------
	// playback dividers and oversample ratio
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			first_power_q <= 1'b0; // RL10
			first_code_q <= ACTC_RST_DIV; // RL11
			second_power_q <= 1'b0; // RL12
			second_code_q <= ACTC_RST_DIV; // RL13
		end
		else if (wr_p0)
		begin
			if (wr.addr == ACTC_OFS_FIRST_DIV)
			begin
				first_power_q <= wr.data[ACTC_POWER_BIT]; // RL10
				first_code_q <= wr.data[6:0]; // RL11
			end
			if (wr.addr == ACTC_OFS_SECOND_DIV)
			begin
				second_power_q <= wr.data[ACTC_POWER_BIT]; // RL12
				second_code_q <= wr.data[6:0]; // RL13
			end
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			osr_up_q <= ACTC_RST_OSR[9:8]; // RL14
			osr_lo_q <= ACTC_RST_OSR[7:0]; // RL14
		end
		else if (wr_p0)
		begin
			if (wr.addr == ACTC_OFS_OSR_UP)
				osr_up_q <= wr.data[1:0]; // RL14
			if (wr.addr == ACTC_OFS_OSR_LO)
				osr_lo_q <= wr.data; // RL14
		end
	end

	// reserved pair kept readable; host is trusted to store zeros
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rsvd_a_q <= 8'h00;
			rsvd_b_q <= 8'h00;
		end
		else if (wr_p0)
		begin
			if (wr.addr == ACTC_OFS_RSVD_A)
				rsvd_a_q <= wr.data;
			if (wr.addr == ACTC_OFS_RSVD_B)
				rsvd_b_q <= wr.data;
		end
	end

	// ----------------------------------------------------------------
	// decoded values for the analog side
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pll_cfg_q <= '0;
			playback_oversample_ratio_q <= {1'b0, ACTC_RST_OSR}; // RL15
		end
		else
		begin
			pll_cfg_q.power <= pll_power_q; // RL3
			pll_cfg_q.prediv <= (prediv_q == ACTC_PREDIV_MAX) ?
				ACTC_PREDIV_FULL : {2'b00, prediv_q}; // RL4
			pll_cfg_q.rmult <= (rmult_q == ACTC_RMULT_MAX) ?
				ACTC_RMULT_FULL : {1'b0, rmult_q}; // RL5
			pll_cfg_q.jmult <= jmult_q; // RL6
			pll_cfg_q.frac <= frac_q; // RL7
			playback_oversample_ratio_q <= ({osr_up_q, osr_lo_q} == 10'h000)
				? ACTC_OSR_FULL : {1'b0, osr_up_q, osr_lo_q}; // RL15
		end
	end

	// overtemperature bit: low while tripped, one after reset
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			thermal_q <= 1'b1; // RL18
		else
			thermal_q <= !overtemp_trip; // RL18
	end

	// ----------------------------------------------------------------
	// read path, one cycle latency
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_mux = 8'h00;
		if (rd_addr == ACTC_OFS_PAGE)
			rd_mux = page_q;
		else if (page_q == 8'h00)
		begin
			case (rd_addr)
				ACTC_OFS_THERMAL: rd_mux = {6'h00, thermal_q, 1'b0}; // RL18
				ACTC_OFS_CLK_MUX: rd_mux = {4'h0, ref_sel_q, codec_sel_q};
				ACTC_OFS_PLL_PR: rd_mux = {pll_power_q, prediv_q, rmult_q};
				ACTC_OFS_PLL_J: rd_mux = {2'b00, jmult_q};
				ACTC_OFS_FRAC_UP: rd_mux = {2'b00, frac_q[13:8]};
				ACTC_OFS_FRAC_LO: rd_mux = frac_q[7:0];
				ACTC_OFS_RSVD_A: rd_mux = rsvd_a_q;
				ACTC_OFS_RSVD_B: rd_mux = rsvd_b_q;
				ACTC_OFS_FIRST_DIV: rd_mux = {first_power_q, first_code_q};
				ACTC_OFS_SECOND_DIV: rd_mux = {second_power_q, second_code_q};
				ACTC_OFS_OSR_UP: rd_mux = {6'h00, osr_up_q};
				ACTC_OFS_OSR_LO: rd_mux = osr_lo_q;
				default: rd_mux = 8'h00; // RL22
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rd_data_q <= 8'h00;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			rd_valid_q <= rd_valid;
			rd_data_q <= rd_valid ? rd_mux : rd_data_q;
		end
	end

	// ----------------------------------------------------------------
	// clock selection and divider chain
	// ----------------------------------------------------------------
	actc_clk_mux u_ref_mux
	(
		.clk(clk),
		.reset(reset),
		.sel(ref_sel_q), // RL1
		.src({data_pin, general_pin_one, bit_pin, master_pin}),
		.out_q(pll_reference_input)
	);
	actc_clk_mux u_codec_mux
	(
		.clk(clk),
		.reset(reset),
		.sel(codec_sel_q), // RL2
		.src({pll_clock, general_pin_one, bit_pin, master_pin}),
		.out_q(codec_clock_input)
	);

	// codec clock sampled as a level; its rise is the divider tick
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			codec_prev_q <= 1'b0;
		else
			codec_prev_q <= codec_clock_input;
	end
	actc_divider #(.WIDTH(7)) u_first_div
	(
		.clk(clk),
		.reset(reset),
		.power(first_power_q), // RL10
		.code(first_code_q), // RL11
		.tick(codec_clock_input && !codec_prev_q),
		.pulse_q(first_div_pulse)
	);
	// second stage only counts first-stage pulses
	actc_divider #(.WIDTH(7)) u_second_div
	(
		.clk(clk),
		.reset(reset),
		.power(second_power_q), // RL12
		.code(second_code_q), // RL13
		.tick(first_div_pulse),
		.pulse_q(second_div_pulse)
	);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_FRAC_PAIR: assert property (@(posedge clk) disable iff (reset) // RL8
		(wr_p0 && wr.addr == ACTC_OFS_FRAC_LO && frac_armed_q) |=>
		frac_q == {$past(frac_up_shadow_q), $past(wr.data)})
		else $error("fraction pair not applied");
	AST_FRAC_HOLD: assert property (@(posedge clk) disable iff (reset) // RL8
		(wr.valid && !(wr_p0 && wr.addr == ACTC_OFS_FRAC_LO && frac_armed_q))
		|=> frac_q[13:8] == $past(frac_q[13:8]))
		else $error("fraction upper changed unpaired");
	AST_THERMAL: assert property (@(posedge clk) disable iff (reset) // RL18
		overtemp_trip |=> !thermal_q)
		else $error("thermal bit not cleared on trip");
	AST_OSR_FULL: assert property (@(posedge clk) disable iff (reset) // RL15
		({osr_up_q, osr_lo_q} == 10'h000) |=>
		playback_oversample_ratio_q == ACTC_OSR_FULL)
		else $error("oversample zero not full");
	AST_PREDIV: assert property (@(posedge clk) disable iff (reset) // RL4
		(prediv_q == ACTC_PREDIV_MAX) |=> pll_cfg_q.prediv == ACTC_PREDIV_FULL)
		else $error("prediv zero not eight");
	AST_RMULT: assert property (@(posedge clk) disable iff (reset) // RL5
		(rmult_q != ACTC_RMULT_MAX) |=> pll_cfg_q.rmult == {1'b0, $past(rmult_q)})
		else $error("r multiplier mismatch");
	AST_DIV_OFF: assert property (@(posedge clk) disable iff (reset) // RL10
		!first_power_q [*2] |-> !first_div_pulse)
		else $error("first divider active while off");
	AST_DIV2_OFF: assert property (@(posedge clk) disable iff (reset) // RL12
		!second_power_q [*2] |-> !second_div_pulse)
		else $error("second divider active while off");
	AST_REF_SEL: assert property (@(posedge clk) disable iff (reset) // RL1
		(ref_sel_q == ACTC_SRC_MASTER && $stable(ref_sel_q)) |=>
		pll_reference_input == $past(master_pin))
		else $error("reference select mismatch");
endmodule : actc_clock_cfg

// ===== actc_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host side register access model
// ----------------------------------------------------------------
module actc_host_model
	import actc_pkg::*;
(
	input wire logic clk,
	output actc_wr_s wr,
	output logic rd_valid,
	output logic [6:0] rd_addr,
	input wire logic rd_valid_q,
	input wire logic [7:0] rd_data_q
);
	// bus idle from time zero, nothing issued until the bench asks
	initial
	begin
		wr = '0;
		rd_valid = 1'b0;
		rd_addr = 7'h00;
	end

	// one write strobe, raised and dropped on falling edges
	// callers keep reserved bits and registers at zero, J nonzero
	task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
		@(negedge clk);
		wr = '{valid: 1'b1, addr: addr, data: data};
		@(negedge clk);
		wr.valid = 1'b0;
	endtask : write_reg

	// lower byte follows the upper one with no write in between
	task automatic write_pair(
		input logic [6:0] addr,
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		write_reg(addr, hi);
		write_reg(addr + 7'h01, lo);
	endtask : write_pair

	// read pulse, then a bounded wait for the registered answer
	task automatic read_reg(
		input logic [6:0] addr,
		output logic [7:0] data,
		output logic ok
	);
		int n;
		@(negedge clk);
		rd_valid = 1'b1;
		rd_addr = addr;
		ok = 1'b0;
		data = 8'h00;
		n = 0;
		// the answer stands one cycle only, so look from the first edge
		while (n < 4 && !ok)
		begin
			@(negedge clk);
			rd_valid = 1'b0;
			if (rd_valid_q === 1'b1)
			begin
				ok = 1'b1;
				data = rd_data_q;
			end
			n++;
		end
	endtask : read_reg
endmodule : actc_host_model

// ===== tb.sv
`timescale 1ns/1ps
module tb
	import actc_pkg::*;
;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk, reset, rd_valid, master_pin, bit_pin, general_pin_one;
	logic data_pin, pll_clock, overtemp_trip, rd_valid_q, rok;
	logic pll_reference_input, codec_clock_input;
	logic first_div_pulse, second_div_pulse;
	logic [6:0] rd_addr;
	logic [7:0] rd_data_q, page_q, rdat;
	logic [10:0] osr_q;
	logic [3:0] hot;
	actc_wr_s wr;
	actc_pll_s pll_q;
	int fail_count, check_count, n1, n2;
	logic [6:0] ra [12] = '{7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08,
		7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h02, 7'h7F};
	logic [7:0] rv [12] = '{8'h02, 8'h00, 8'h11, 8'h04, 8'h00, 8'h00,
		8'h01, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00};

	actc_clock_cfg dut (.clk(clk), .reset(reset), .wr(wr),
		.rd_valid(rd_valid), .rd_addr(rd_addr), .master_pin(master_pin),
		.bit_pin(bit_pin), .general_pin_one(general_pin_one),
		.data_pin(data_pin), .pll_clock(pll_clock),
		.overtemp_trip(overtemp_trip), .rd_data_q(rd_data_q),
		.rd_valid_q(rd_valid_q), .pll_reference_input(pll_reference_input),
		.codec_clock_input(codec_clock_input), .pll_cfg_q(pll_q),
		.first_div_pulse(first_div_pulse),
		.second_div_pulse(second_div_pulse),
		.playback_oversample_ratio_q(osr_q), .page_q(page_q));

	actc_host_model host (.clk(clk), .wr(wr), .rd_valid(rd_valid),
		.rd_addr(rd_addr), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q));

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// divider pulse counters, cleared by the sequence
	always @(posedge clk)
	begin
		if (first_div_pulse === 1'b1)
			n1++;
		if (second_div_pulse === 1'b1)
			n2++;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// a lost answer ends the run at once
	task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
		host.read_reg(addr, rdat, rok);
		if (rok !== 1'b1)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
			tally_and_finish();
		end
		else
			check(32'(rdat), 32'(exp));
	endtask : rd_chk

	// codec source rises, two cycles high and two low each
	task automatic ticks(input int n);
		repeat (n)
		begin
			@(negedge clk);
			master_pin = 1'b1;
			repeat (2) @(negedge clk);
			master_pin = 1'b0;
			@(negedge clk);
		end
		repeat (4) @(negedge clk);
	endtask : ticks

	task automatic settle;
		repeat (3) @(negedge clk);
	endtask : settle

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		{data_pin, general_pin_one, bit_pin, master_pin} = 4'h0;
		pll_clock = 1'b0;
		overtemp_trip = 1'b0;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		settle();
		// reset values, reserved and unmapped reads
		for (int i = 0; i < 12; i++)
			rd_chk(ra[i], rv[i]);
		check(32'(pll_q), 32'({1'b0, 5'h01, 5'h01, 6'h04, 14'h0000}));
		check(32'(osr_q), 32'h080);
		check(32'(page_q), 32'h00);
		// every source code on both selectors, high then low
		for (int i = 0; i < 4; i++)
		begin
			host.write_reg(ACTC_OFS_CLK_MUX, 8'(i * 5));
			hot = 4'h1 << i;
			{data_pin, general_pin_one, bit_pin, master_pin} = hot;
			pll_clock = hot[3];
			settle();
			check(32'(pll_reference_input), 32'h1);
			check(32'(codec_clock_input), 32'h1);
			{data_pin, general_pin_one, bit_pin, master_pin} = ~hot;
			pll_clock = ~hot[3];
			settle();
			check(32'(pll_reference_input), 32'h0);
			check(32'(codec_clock_input), 32'h0);
		end
		{data_pin, general_pin_one, bit_pin, master_pin} = 4'h0;
		pll_clock = 1'b0;
		// pll fields at their extreme codes
		host.write_reg(ACTC_OFS_PLL_PR, 8'h80);
		settle();
		check(32'(pll_q.power), 32'h1);
		check(32'(pll_q.prediv), 32'h8);
		check(32'(pll_q.rmult), 32'h10);
		host.write_reg(ACTC_OFS_PLL_PR, 8'h7F);
		host.write_reg(ACTC_OFS_PLL_J, 8'h3F);
		settle();
		check(32'(pll_q.power), 32'h0);
		check(32'(pll_q.prediv), 32'h7);
		check(32'(pll_q.rmult), 32'hF);
		check(32'(pll_q.jmult), 32'h3F);
		// fraction pair, then an upper byte broken off by another write
		host.write_pair(ACTC_OFS_FRAC_UP, 8'h2A, 8'h55);
		settle();
		check(32'(pll_q.frac), 32'h2A55);
		host.write_reg(ACTC_OFS_FRAC_UP, 8'h11);
		host.write_reg(ACTC_OFS_PLL_J, 8'h04);
		host.write_reg(ACTC_OFS_FRAC_LO, 8'h33);
		settle();
		check(32'(pll_q.frac), 32'h2A33);
		rd_chk(ACTC_OFS_FRAC_LO, 8'h33);
		// oversampling: full code, top code, a multiple of eight
		host.write_pair(ACTC_OFS_OSR_UP, 8'h00, 8'h00);
		settle();
		check(32'(osr_q), 32'h400);
		host.write_pair(ACTC_OFS_OSR_UP, 8'h03, 8'hFF);
		settle();
		check(32'(osr_q), 32'h3FF);
		host.write_pair(ACTC_OFS_OSR_UP, 8'h00, 8'h40);
		settle();
		check(32'(osr_q), 32'h040);
		// dividers on the master source
		host.write_reg(ACTC_OFS_CLK_MUX, 8'h00);
		host.write_reg(ACTC_OFS_FIRST_DIV, 8'h82);
		host.write_reg(ACTC_OFS_SECOND_DIV, 8'h83);
		n1 = 0;
		n2 = 0;
		ticks(12);
		check(32'(n1), 32'd6);
		check(32'(n2), 32'd2);
		host.write_reg(ACTC_OFS_FIRST_DIV, 8'h80);
		host.write_reg(ACTC_OFS_SECOND_DIV, 8'h81);
		n1 = 0;
		n2 = 0;
		ticks(256);
		check(32'(n1), 32'd2);
		check(32'(n2), 32'd2);
		host.write_reg(ACTC_OFS_FIRST_DIV, 8'h01);
		n1 = 0;
		ticks(4);
		check(32'(n1), 32'd0);
		host.write_reg(ACTC_OFS_FIRST_DIV, 8'h81);
		host.write_reg(ACTC_OFS_SECOND_DIV, 8'h01);
		n1 = 0;
		n2 = 0;
		ticks(4);
		check(32'(n1), 32'd4);
		check(32'(n2), 32'd0);
		// thermal flag is low while tripped
		overtemp_trip = 1'b1;
		settle();
		rd_chk(ACTC_OFS_THERMAL, 8'h00);
		overtemp_trip = 1'b0;
		settle();
		rd_chk(ACTC_OFS_THERMAL, 8'h02);
		host.write_reg(ACTC_OFS_RSVD_A, 8'h00);
		rd_chk(ACTC_OFS_RSVD_A, 8'h00);
		host.write_reg(ACTC_OFS_RSVD_B, 8'h00);
		rd_chk(ACTC_OFS_RSVD_B, 8'h00);
		// another page hides and protects page 0
		host.write_reg(ACTC_OFS_PAGE, 8'h01);
		settle();
		check(32'(page_q), 32'h01);
		rd_chk(ACTC_OFS_PAGE, 8'h01);
		host.write_reg(ACTC_OFS_FIRST_DIV, 8'h7F);
		rd_chk(ACTC_OFS_FIRST_DIV, 8'h00);
		host.write_reg(ACTC_OFS_PAGE, 8'h00);
		rd_chk(ACTC_OFS_FIRST_DIV, 8'h81);
		// reset in mid-run brings every field back to its reset code
		@(negedge clk);
		reset = 1'b1;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		settle();
		rd_chk(ACTC_OFS_FIRST_DIV, 8'h01);
		rd_chk(ACTC_OFS_FRAC_LO, 8'h00);
		rd_chk(ACTC_OFS_PLL_J, 8'h04);
		check(32'(osr_q), 32'h080);
		tally_and_finish();
	end
endmodule : tb
